// ### gpio_lines.sv
// five single-bit gpio lines plus an eight-bit strobed byte bus
// assumes pins are asynchronous; pad logic resolves in/out/oe_n per pin
`timescale 1ns/1ps

// What this block does
// - thirteen user lines: five single lines and an eight-line byte group
// - after reset every line is an input and drives nothing
// - each single line has its own independent direction bit
// - the eight byte lines are read and written only as a whole byte
// - each byte transfer is a low strobe pulse of at least 50 ns
// - the read strobe pulse captures the byte lines into the holding latch
// - the write strobe pulse drives the held byte onto the byte lines
// - lines four and five act as read and write strobes in byte mode
// - jumpers pick the alternate roles of lines one to three
// - frame role: line one is an input flagging each frame start
// - battery role: line two is an input flagging low battery
// - supply role: line three driven high enables card and display
// - supply role as input leaves the level to the outside circuit
// - alternate roles: frame on one, battery on two, supply on three
module gpio_lines (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // software single-line control, bit 0 is line one
  input  wire logic [4:0] line_dir,
  input  wire logic [4:0] line_out,
  output logic      [4:0] line_in,
  // software byte-bus control
  input  wire logic       byte_bus_en,
  input  wire logic [7:0] byte_out,
  input  wire logic       byte_rd_req,
  input  wire logic       byte_wr_req,
  output logic      [7:0] byte_in,
  output logic            byte_busy,
  output logic            byte_rd_done,
  // jumper straps, high when closed
  input  wire logic       supply_enable_jumper,
  input  wire logic       frame_indicator_jumper,
  input  wire logic       battery_status_jumper,
  // alternate-role status
  output logic            frame_start,
  output logic            battery_low,
  output logic            supply_on,
  // line one pin
  input  wire logic       line_one_frame_indicator_in,
  output logic            line_one_frame_indicator_out,
  output logic            line_one_frame_indicator_oe_n,
  // line two pin
  input  wire logic       line_two_battery_status_in,
  output logic            line_two_battery_status_out,
  output logic            line_two_battery_status_oe_n,
  // line three pin
  input  wire logic       line_three_supply_enable_in,
  output logic            line_three_supply_enable_out,
  output logic            line_three_supply_enable_oe_n,
  // line four pin
  input  wire logic       line_four_read_strobe_in,
  output logic            line_four_read_strobe_out,
  output logic            line_four_read_strobe_oe_n,
  // line five pin
  input  wire logic       line_five_write_strobe_in,
  output logic            line_five_write_strobe_out,
  output logic            line_five_write_strobe_oe_n,
  // byte lines
  input  wire logic [7:0] parallel_byte_lines_in,
  output logic      [7:0] parallel_byte_lines_out,
  output logic      [7:0] parallel_byte_lines_oe_n
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [gpio_pkg::N_LINES-1:0] pin_s;
  logic [gpio_pkg::BYTE_W-1:0]  byte_s;
  logic [gpio_pkg::N_JMP-1:0]   jmp_s;

  sync2 #(.W(gpio_pkg::N_LINES)) u_sync_lines (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d_async ({line_five_write_strobe_in, line_four_read_strobe_in,
               line_three_supply_enable_in, line_two_battery_status_in,
               line_one_frame_indicator_in}),
    .q_sync  (pin_s)
  );

  sync2 #(.W(gpio_pkg::BYTE_W)) u_sync_byte (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d_async (parallel_byte_lines_in),
    .q_sync  (byte_s)
  );

  // jumpers are static straps, synchronised all the same
  sync2 #(.W(gpio_pkg::N_JMP)) u_sync_jmp (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d_async ({battery_status_jumper, frame_indicator_jumper,
               supply_enable_jumper}),
    .q_sync  (jmp_s)
  );

  // ----------------------------------------------------------------
  // strobe sequencer
  // ----------------------------------------------------------------
  strobe_ctl_if sctl ();

  strobe_seq u_seq (
    .sys_clk (sys_clk),
    .srst    (srst),
    .ctl     (sctl)
  );

  // requests only count in byte mode and while idle
  assign sctl.rd_req = byte_bus_en && byte_rd_req && !sctl.busy;
  assign sctl.wr_req = byte_bus_en && byte_wr_req && !sctl.busy &&
                       !byte_rd_req;

  // ----------------------------------------------------------------
  // role selection
  // ----------------------------------------------------------------
  logic alt_frame;
  logic alt_batt;
  logic alt_supply;

  // closed jumper selects the alternate role
  assign alt_frame  = jmp_s[gpio_pkg::JMP_FRAME];
  assign alt_batt   = jmp_s[gpio_pkg::JMP_BATT];
  assign alt_supply = jmp_s[gpio_pkg::JMP_SUPPLY];

  // ----------------------------------------------------------------
  // per-line drive
  // ----------------------------------------------------------------
  logic [gpio_pkg::N_LINES-1:0] oe_n_nxt;
  logic [gpio_pkg::N_LINES-1:0] out_nxt;
  logic [gpio_pkg::N_LINES-1:0] oe_n_r;
  logic [gpio_pkg::N_LINES-1:0] out_r;

  // software direction per line, then role overrides
  always_comb begin
    oe_n_nxt = ~line_dir;
    out_nxt  = line_out;
    if (alt_frame) begin
      oe_n_nxt[gpio_pkg::IDX_FRAME] = 1'b1;
    end
    if (alt_batt) begin
      oe_n_nxt[gpio_pkg::IDX_BATT] = 1'b1;
    end
    // supply role keeps software direction: output high enables,
    // output low disables, input hands the level to the outside
    if (alt_supply && line_dir[gpio_pkg::IDX_SUPPLY]) begin
      out_nxt[gpio_pkg::IDX_SUPPLY] = line_out[gpio_pkg::IDX_SUPPLY];
    end
    if (byte_bus_en) begin
      oe_n_nxt[gpio_pkg::IDX_RD] = 1'b0;
      oe_n_nxt[gpio_pkg::IDX_WR] = 1'b0;
      out_nxt[gpio_pkg::IDX_RD]  = !sctl.rd_low;
      out_nxt[gpio_pkg::IDX_WR]  = !sctl.wr_low;
    end
  end

  // registered pin drive, all released in reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      oe_n_r <= gpio_pkg::LINE_OE_N_RST;
      out_r  <= gpio_pkg::LINE_OUT_RST;
    end else begin
      oe_n_r <= oe_n_nxt;
      out_r  <= out_nxt;
    end
  end

  assign line_one_frame_indicator_out   = out_r[gpio_pkg::IDX_FRAME];
  assign line_one_frame_indicator_oe_n  = oe_n_r[gpio_pkg::IDX_FRAME];
  assign line_two_battery_status_out    = out_r[gpio_pkg::IDX_BATT];
  assign line_two_battery_status_oe_n   = oe_n_r[gpio_pkg::IDX_BATT];
  assign line_three_supply_enable_out   = out_r[gpio_pkg::IDX_SUPPLY];
  assign line_three_supply_enable_oe_n  = oe_n_r[gpio_pkg::IDX_SUPPLY];
  assign line_four_read_strobe_out      = out_r[gpio_pkg::IDX_RD];
  assign line_four_read_strobe_oe_n     = oe_n_r[gpio_pkg::IDX_RD];
  assign line_five_write_strobe_out     = out_r[gpio_pkg::IDX_WR];
  assign line_five_write_strobe_oe_n    = oe_n_r[gpio_pkg::IDX_WR];

  // ----------------------------------------------------------------
  // single-line readback and role status
  // ----------------------------------------------------------------
  logic frame_prev_r;

  // readback registered once more so outputs come from flops
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      line_in      <= gpio_pkg::LINE_OUT_RST;
      frame_prev_r <= 1'b0;
      frame_start  <= 1'b0;
      battery_low  <= 1'b0;
      supply_on    <= 1'b0;
    end else begin
      line_in      <= pin_s;
      frame_prev_r <= pin_s[gpio_pkg::IDX_FRAME];
      // rising edge marks a new frame; one-cycle pulse
      frame_start  <= alt_frame && pin_s[gpio_pkg::IDX_FRAME] &&
                      !frame_prev_r;
      battery_low  <= alt_batt && pin_s[gpio_pkg::IDX_BATT];
      // actual pin level, whoever drives it
      supply_on    <= alt_supply && pin_s[gpio_pkg::IDX_SUPPLY];
    end
  end

  // ----------------------------------------------------------------
  // byte bus data path
  // ----------------------------------------------------------------
  logic [gpio_pkg::BYTE_W-1:0] hold_out_r;

  // whole-byte latches only; no per-bit access exists
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hold_out_r   <= gpio_pkg::BYTE_RST;
      byte_in      <= gpio_pkg::BYTE_RST;
      byte_rd_done <= 1'b0;
    end else begin
      if (sctl.wr_req) begin
        hold_out_r <= byte_out;
      end
      if (sctl.rd_done) begin
        byte_in <= byte_s;
      end
      byte_rd_done <= sctl.rd_done;
    end
  end

  // drive registers: released except around a write pulse
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      parallel_byte_lines_out  <= gpio_pkg::BYTE_RST;
      parallel_byte_lines_oe_n <= gpio_pkg::BYTE_OE_N_RST;
      byte_busy                <= 1'b0;
    end else begin
      parallel_byte_lines_out  <= hold_out_r;
      parallel_byte_lines_oe_n <= {gpio_pkg::BYTE_W{!sctl.wr_drive}};
      byte_busy                <= sctl.busy || sctl.rd_req || sctl.wr_req;
    end
  end

endmodule // gpio_lines

// ### gpio_pkg.sv
// constants, states and timing counts for the gpio line and byte-bus block
// assumes a single 100 MHz clock domain and no register bus
package gpio_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned N_LINES = 5;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned N_JMP   = 3;

  // ----------------------------------------------------------------
  // line positions inside the five-bit single-line vectors
  // ----------------------------------------------------------------
  localparam int unsigned IDX_FRAME  = 0;
  localparam int unsigned IDX_BATT   = 1;
  localparam int unsigned IDX_SUPPLY = 2;
  localparam int unsigned IDX_RD     = 3;
  localparam int unsigned IDX_WR     = 4;

  // jumper positions inside the three-bit jumper vector
  localparam int unsigned JMP_SUPPLY = 0;
  localparam int unsigned JMP_FRAME  = 1;
  localparam int unsigned JMP_BATT   = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [N_LINES-1:0] LINE_OUT_RST  = 5'h00;
  localparam logic [N_LINES-1:0] LINE_OE_N_RST = 5'h1F;
  localparam logic [BYTE_W-1:0]  BYTE_RST      = 8'h00;
  localparam logic [BYTE_W-1:0]  BYTE_OE_N_RST = 8'hFF;

  // ----------------------------------------------------------------
  // strobe timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned STROBE_MIN_NS  = 50;
  // least time, so round up
  localparam int unsigned STROBE_CYCLES  =
    (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 3;
  localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO    = 3'h0;

  // strobe sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_LOW,
    ST_WR_SETUP,
    ST_WR_LOW,
    ST_RECOVER
  } strobe_state_t;

endpackage

// ### strobe_ctl_if.sv
// request and status bundle between the gpio top and its strobe sequencer
// assumes both ends sit on sys_clk
`timescale 1ns/1ps

interface strobe_ctl_if;
  logic rd_req;    // start a read transfer, one-cycle pulse
  logic wr_req;    // start a write transfer, one-cycle pulse
  logic busy;      // sequencer not idle
  logic rd_low;    // read strobe pin level request, low = active
  logic wr_low;    // write strobe pin level request, low = active
  logic rd_done;   // last cycle of the read pulse, capture now
  logic wr_drive;  // byte lines must be driven

  modport ctl (output rd_req, output wr_req,
               input busy, input rd_low, input wr_low,
               input rd_done, input wr_drive);
  modport gen (input rd_req, input wr_req,
               output busy, output rd_low, output wr_low,
               output rd_done, output wr_drive);
endinterface // strobe_ctl_if

// ### sync2.sv
// two-flop synchroniser, width set by parameter
// assumes inputs are asynchronous to sys_clk
`timescale 1ns/1ps

module sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         srst,
  // asynchronous input and synchronised output
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q_sync
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r <= '0;
      q_sync <= '0;
    end else begin
      meta_r <= d_async;
      q_sync <= meta_r;
    end
  end

endmodule // sync2

// ### strobe_seq.sv
// sequencer for the low-active read and write strobes of the byte bus
// assumes requests arrive as one-cycle pulses from the gpio top
`timescale 1ns/1ps

module strobe_seq (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // control bundle
  strobe_ctl_if.gen ctl
);

  gpio_pkg::strobe_state_t    state_r;
  logic [gpio_pkg::CNT_W-1:0] cnt_r;
  logic                       wr_last_r;

  // ----------------------------------------------------------------
  // state and pulse counter
  // ----------------------------------------------------------------
  // read wins when both requests land together
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= gpio_pkg::ST_IDLE;
      cnt_r   <= gpio_pkg::CNT_ZERO;
    end else begin
      case (state_r)
        gpio_pkg::ST_IDLE: begin
          cnt_r <= gpio_pkg::CNT_ZERO;
          if (ctl.rd_req) begin
            state_r <= gpio_pkg::ST_RD_LOW;
          end else if (ctl.wr_req) begin
            state_r <= gpio_pkg::ST_WR_SETUP;
          end
        end
        gpio_pkg::ST_RD_LOW, gpio_pkg::ST_WR_LOW: begin
          if (cnt_r == gpio_pkg::STROBE_LAST) begin
            state_r <= gpio_pkg::ST_RECOVER;
            cnt_r   <= gpio_pkg::CNT_ZERO;
          end else begin
            cnt_r <= cnt_r + 3'h1;
          end
        end
        gpio_pkg::ST_WR_SETUP: state_r <= gpio_pkg::ST_WR_LOW;
        gpio_pkg::ST_RECOVER:  state_r <= gpio_pkg::ST_IDLE;
        default:               state_r <= gpio_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  // strobes idle high; byte lines driven from setup through recovery
  // so the far side sees data settled around the rising edge
  always_comb begin
    ctl.busy     = (state_r != gpio_pkg::ST_IDLE);
    ctl.rd_low   = (state_r == gpio_pkg::ST_RD_LOW);
    ctl.wr_low   = (state_r == gpio_pkg::ST_WR_LOW);
    ctl.rd_done  = (state_r == gpio_pkg::ST_RD_LOW) &&
                   (cnt_r == gpio_pkg::STROBE_LAST);
    ctl.wr_drive = (state_r == gpio_pkg::ST_WR_SETUP) ||
                   (state_r == gpio_pkg::ST_WR_LOW)   ||
                   ((state_r == gpio_pkg::ST_RECOVER) &&
                    (cnt_r == gpio_pkg::CNT_ZERO) && wr_last_r);
  end

  // remembers that the pulse just ended was a write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_last_r <= 1'b0;
    end else if (state_r == gpio_pkg::ST_WR_LOW) begin
      wr_last_r <= 1'b1;
    end else if (state_r == gpio_pkg::ST_RD_LOW) begin
      wr_last_r <= 1'b0;
    end
  end

endmodule // strobe_seq

// ### gpio_lines_sva.sv
// concurrent checks on the gpio line and byte-bus block
// assumes only the top module's ports; bound below the module
`timescale 1ns/1ps

module gpio_lines_sva (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       srst,
  // control and status
  input wire logic [4:0] line_dir,
  input wire logic [4:0] line_in,
  input wire logic       byte_bus_en,
  input wire logic       byte_rd_req,
  input wire logic       byte_wr_req,
  input wire logic       byte_busy,
  input wire logic       byte_rd_done,
  input wire logic       frame_indicator_jumper,
  // pins
  input wire logic       line_one_frame_indicator_in,
  input wire logic       line_one_frame_indicator_oe_n,
  input wire logic       line_three_supply_enable_oe_n,
  input wire logic       line_four_read_strobe_out,
  input wire logic       line_four_read_strobe_oe_n,
  input wire logic       line_five_write_strobe_out,
  input wire logic       line_five_write_strobe_oe_n,
  input wire logic [7:0] parallel_byte_lines_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // --------------------------------------------------------------
  // strobe pulse shapes
  // --------------------------------------------------------------
  // read: five low cycles, capture flagged in the last low cycle
  sequence rd_pulse_s;
    (!line_four_read_strobe_out)[*4] ##1
    (!line_four_read_strobe_out && byte_rd_done) ##1
    (line_four_read_strobe_out && !byte_rd_done);
  endsequence
  // write: data driven across the pulse and one cycle past it
  sequence wr_pulse_s;
    (!line_five_write_strobe_out && parallel_byte_lines_oe_n == 8'h00)[*5]
    ##1 (line_five_write_strobe_out && parallel_byte_lines_oe_n == 8'h00)
    ##1 (parallel_byte_lines_oe_n == 8'hFF);
  endsequence

  chk_reset_released: assert property (
    $fell(srst) |-> (&{line_one_frame_indicator_oe_n,
      line_three_supply_enable_oe_n, line_four_read_strobe_oe_n,
      line_five_write_strobe_oe_n, parallel_byte_lines_oe_n}))
    else $error("line driven after reset");
  chk_rd_pulse: assert property (
    $fell(line_four_read_strobe_out) && byte_busy |-> rd_pulse_s)
    else $error("read strobe pulse wrong");
  chk_wr_pulse: assert property (
    $fell(line_five_write_strobe_out) && byte_busy |-> wr_pulse_s)
    else $error("write strobe pulse wrong");
  chk_rd_latency: assert property (
    byte_bus_en && byte_rd_req && !byte_busy &&
    !$past(byte_rd_req || byte_wr_req) |-> ##6 byte_rd_done)
    else $error("read capture late or missing");
  chk_wr_start: assert property (
    byte_bus_en && byte_wr_req && !byte_rd_req && !byte_busy &&
    !$past(byte_rd_req || byte_wr_req) |->
    ##2 (parallel_byte_lines_oe_n == 8'h00) ##1 !line_five_write_strobe_out)
    else $error("write start wrong");
  chk_rd_undriven: assert property (
    !line_four_read_strobe_out && !line_four_read_strobe_oe_n && byte_busy
    |-> parallel_byte_lines_oe_n == 8'hFF)
    else $error("byte lines driven during read");
  chk_strobe_idle: assert property (
    byte_bus_en && $past(byte_bus_en) && !byte_busy |->
    line_four_read_strobe_out && line_five_write_strobe_out &&
    !line_four_read_strobe_oe_n && !line_five_write_strobe_oe_n)
    else $error("strobes not idle high");
  chk_dir_three: assert property (
    !$past(srst) |->
    line_three_supply_enable_oe_n == !$past(line_dir[2]))
    else $error("line three direction wrong");
  chk_frame_input: assert property (
    frame_indicator_jumper[*5] |-> line_one_frame_indicator_oe_n)
    else $error("frame line not an input");
  chk_line_sync: assert property (
    !($past(srst) || $past(srst, 2) || $past(srst, 3)) |->
    line_in[0] == $past(line_one_frame_indicator_in, 3))
    else $error("line one input delay wrong");
endmodule // gpio_lines_sva

bind gpio_lines gpio_lines_sva chk_u (
  .sys_clk, .srst, .line_dir, .line_in, .byte_bus_en, .byte_rd_req,
  .byte_wr_req, .byte_busy, .byte_rd_done, .frame_indicator_jumper,
  .line_one_frame_indicator_in, .line_one_frame_indicator_oe_n,
  .line_three_supply_enable_oe_n, .line_four_read_strobe_out,
  .line_four_read_strobe_oe_n, .line_five_write_strobe_out,
  .line_five_write_strobe_oe_n, .parallel_byte_lines_oe_n);

// ### byte_bus_party.sv
// far-side circuit sharing the eight byte lines with the block
// assumes it sees the resolved strobe pin levels from the bench
`timescale 1ns/1ps

module byte_bus_party (
  // clock
  input  wire logic       sys_clk,
  // strobe pin levels
  input  wire logic       rd_pin,
  input  wire logic       wr_pin,
  // byte lines as driven by the device
  input  wire logic [7:0] dev_out,
  input  wire logic [7:0] dev_oe_n,
  // byte offered on reads
  input  wire logic [7:0] rd_byte,
  // resolved lines and latched write byte
  output logic      [7:0] bus_lvl,
  output logic      [7:0] wr_byte,
  output logic            wr_evt
);
  logic [7:0] idle_r;

  // no pull on these lines, so released bits flip every cycle
  initial idle_r = 8'hA5;
  always @(posedge sys_clk) idle_r <= ~bus_lvl;
  // drive only while the read strobe is low, held through the pulse
  assign bus_lvl = (dev_out & ~dev_oe_n)
                 | ((rd_pin ? idle_r : rd_byte) & dev_oe_n);

  // latch on the strobe's rising edge, only if the device drives
  initial wr_evt = 1'b0;
  always @(posedge wr_pin) if (dev_oe_n === 8'h00) begin
    wr_byte <= bus_lvl;
    wr_evt  <= ~wr_evt;
  end
endmodule // byte_bus_party

// ### gpio_lines_tb_top.sv
// self-checking bench for the gpio line and byte-bus block
// assumes the far-side model and the bound checker are compiled first
`timescale 1ns/1ps

module gpio_lines_tb_top;
  logic       sys_clk, srst, byte_bus_en, byte_rd_req, byte_wr_req;
  logic       byte_busy, byte_rd_done, frame_start, battery_low, supply_on;
  logic       supply_enable_jumper, frame_indicator_jumper, wr_evt;
  logic       battery_status_jumper;
  logic [4:0] line_dir, line_out, line_in, ext, oe_v, out_v, pin_v;
  logic [7:0] byte_out, byte_in, rd_byte, wr_byte, lfsr_r;
  logic [7:0] parallel_byte_lines_in, parallel_byte_lines_out;
  logic [7:0] parallel_byte_lines_oe_n, rd_q[$], wr_q[$];
  logic line_one_frame_indicator_out, line_one_frame_indicator_oe_n;
  logic line_two_battery_status_out, line_two_battery_status_oe_n;
  logic line_three_supply_enable_out, line_three_supply_enable_oe_n;
  logic line_four_read_strobe_out, line_four_read_strobe_oe_n;
  logic line_five_write_strobe_out, line_five_write_strobe_oe_n;
  int         err_count, check_count, n;

  // --------------------------------------------------------------
  // pins: released lines take the bench's own drive
  // --------------------------------------------------------------
  assign oe_v = {line_five_write_strobe_oe_n, line_four_read_strobe_oe_n,
    line_three_supply_enable_oe_n, line_two_battery_status_oe_n,
    line_one_frame_indicator_oe_n};
  assign out_v = {line_five_write_strobe_out, line_four_read_strobe_out,
    line_three_supply_enable_out, line_two_battery_status_out,
    line_one_frame_indicator_out};
  assign pin_v = (oe_v & ext) | (~oe_v & out_v);
  wire line_one_frame_indicator_in   = pin_v[0];
  wire line_two_battery_status_in    = pin_v[1];
  wire line_three_supply_enable_in   = pin_v[2];
  wire line_four_read_strobe_in      = pin_v[3];
  wire line_five_write_strobe_in     = pin_v[4];

  gpio_lines dut_u (.sys_clk, .srst, .line_dir, .line_out, .line_in,
    .byte_bus_en, .byte_out, .byte_rd_req, .byte_wr_req, .byte_in,
    .byte_busy, .byte_rd_done, .supply_enable_jumper,
    .frame_indicator_jumper, .battery_status_jumper, .frame_start,
    .battery_low, .supply_on, .line_one_frame_indicator_in,
    .line_one_frame_indicator_out, .line_one_frame_indicator_oe_n,
    .line_two_battery_status_in, .line_two_battery_status_out,
    .line_two_battery_status_oe_n, .line_three_supply_enable_in,
    .line_three_supply_enable_out, .line_three_supply_enable_oe_n,
    .line_four_read_strobe_in, .line_four_read_strobe_out,
    .line_four_read_strobe_oe_n, .line_five_write_strobe_in,
    .line_five_write_strobe_out, .line_five_write_strobe_oe_n,
    .parallel_byte_lines_in, .parallel_byte_lines_out,
    .parallel_byte_lines_oe_n);
  byte_bus_party far_u (.sys_clk, .rd_pin(pin_v[3]), .wr_pin(pin_v[4]),
    .dev_out(parallel_byte_lines_out), .dev_oe_n(parallel_byte_lines_oe_n),
    .rd_byte, .bus_lvl(parallel_byte_lines_in), .wr_byte, .wr_evt);

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one request; late adds a write while busy, which must be dropped
  task automatic xfer(input logic [1:0] req, input logic [7:0] b,
                      input logic late);
    int k;
    {rd_byte, byte_out} = {b, b};
    {byte_wr_req, byte_rd_req} = req;
    if (byte_bus_en && req[0]) rd_q.push_back(b);
    else if (byte_bus_en && req[1]) wr_q.push_back(b);
    @(negedge sys_clk);
    {byte_wr_req, byte_rd_req} = {late, 1'b0};
    @(negedge sys_clk);
    byte_wr_req = 1'b0;
    for (k = 0; k < 30 && byte_busy !== 1'b0; k++) @(negedge sys_clk);
    if (k == 30) check(8'h01, 8'h00);
  endtask

  // a result with nothing expected counts as a mismatch
  always @(negedge sys_clk) if (!srst && byte_rd_done === 1'b1) begin
    if (rd_q.size() == 0) check(8'h01, 8'h00);
    else check(byte_in, rd_q.pop_front());
  end
  always @(wr_evt) if (!srst) begin
    if (wr_q.size() == 0) check(8'h01, 8'h00);
    else check(wr_byte, wr_q.pop_front());
  end

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // about 200 cycles of work; a hang stops well past that
  initial begin
    #100000;
    err_count++;
    results();
  end

  initial begin
    {srst, byte_bus_en, byte_rd_req, byte_wr_req} = 4'h8;
    {supply_enable_jumper, frame_indicator_jumper, battery_status_jumper}
      = 3'h0;
    {line_dir, line_out, ext} = 15'h001F;
    {byte_out, rd_byte, lfsr_r} = 24'h000031;
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    check({3'h0, oe_v}, 8'h1F);
    check(parallel_byte_lines_oe_n, 8'hFF);
    // one output at a time; the rest read back the bench's own levels
    for (int i = 0; i < 5; i++) begin
      lfsr_r = lfsr(lfsr_r);
      line_dir = 5'h01 << i;
      {line_out, ext} = {lfsr_r[4:0], ~lfsr_r[4:0]};
      repeat (5) @(negedge sys_clk);
      check({3'h0, oe_v}, {3'h0, ~line_dir});
      check({3'h0, out_v & line_dir}, {3'h0, line_out & line_dir});
      check({3'h0, line_in}, {3'h0, pin_v});
    end
    // alternate roles: one and two forced input, three follows software
    {line_dir, line_out, ext} = 15'h1C98;
    {supply_enable_jumper, frame_indicator_jumper, battery_status_jumper}
      = 3'h7;
    repeat (6) @(negedge sys_clk);
    check({3'h0, oe_v}, 8'h1B);
    check({5'h0, frame_start, battery_low, supply_on}, 8'h01);
    ext = 5'h1B;
    n = 0;
    repeat (8) begin
      @(negedge sys_clk);
      n += int'(frame_start);
    end
    check(8'(n), 8'h01);
    check({5'h0, frame_start, battery_low, supply_on}, 8'h03);
    {line_dir, ext} = 10'h018;
    repeat (6) @(negedge sys_clk);
    check({3'h0, oe_v}, 8'h1F);
    check({5'h0, frame_start, battery_low, supply_on}, 8'h00);
    ext = 5'h1C;
    repeat (6) @(negedge sys_clk);
    check({5'h0, frame_start, battery_low, supply_on}, 8'h01);
    // byte bus: strobes idle high, then reads and writes back to back
    {supply_enable_jumper, frame_indicator_jumper, battery_status_jumper}
      = 3'h0;
    byte_bus_en = 1'b1;
    repeat (3) @(negedge sys_clk);
    check({4'h0, out_v[4:3], oe_v[4:3]}, 8'h0C);
    for (int i = 0; i < 6; i++) begin
      lfsr_r = lfsr(lfsr_r);
      xfer(2'b01, lfsr_r, 1'b0);
      lfsr_r = lfsr(lfsr_r);
      xfer(2'b10, ~lfsr_r, 1'b0);
    end
    xfer(2'b11, 8'hC3, 1'b0);
    xfer(2'b01, 8'h3C, 1'b1);
    byte_bus_en = 1'b0;
    xfer(2'b01, 8'h5A, 1'b0);
    repeat (12) @(negedge sys_clk);
    check(8'(rd_q.size() + wr_q.size()), 8'h00);
    results();
  end
endmodule // gpio_lines_tb_top
